// ---- src/frpe_top.sv ----
// Flash row programming sequencer and always-on SEC-DED program memory code
//
// What this block does
// - Fetch two instructions, program at destination
// - Advance both addresses until row done
// - Control bit 9 selects compressed layout
// - Compressed: second MSB from word upper byte
// - Completion pulse after each row program
// - Error correction always on, no disable
// - Seven-bit Hamming parity per instruction pair
// - 48 data plus 7 parity, parity not in read data
// - Recompute parity on read, compare stored
// - Single-bit error corrected in read data
// - Double-bit error returns data unchanged
// - Single error sets flag 13, gated irq
// - Status low: expected and actual parity
// - Status high low byte gives syndrome
// - No error: status keeps last error's values
// - Double error: hard trap, source bit 1
// - No handler installed: also device reset
// - Status high holds both double parity bits
`timescale 1ns/1ps

module frpe_top (
  input  wire logic                    core_clk_i,
  input  wire logic                    reset_i,
  input  wire logic [7:0]              reg_addr_i,
  input  wire logic [15:0]             reg_wdata_i,
  input  wire logic                    reg_wr_i,
  input  wire logic                    reg_rd_i,
  output logic      [15:0]             reg_rdata_o,
  output logic                         ram_rd_o,
  output logic      [23:0]             ram_addr_o,
  input  wire logic [15:0]             ram_rdata_i,
  output logic                         flash_wr_o,
  output logic      [23:0]             flash_addr_o,
  output frpe_pkg::frpe_codeword_s     flash_wdata_o,
  input  wire logic                    flash_done_i,
  input  wire logic                    fetch_valid_i,
  input  wire frpe_pkg::frpe_codeword_s fetch_word_i,
  output logic                         fetch_valid_o,
  output logic      [47:0]             fetch_data_o,
  output logic                         busy_o,
  output logic                         flash_done_irq_o,
  output logic                         ecc_irq_o,
  output logic                         hard_trap_o,
  input  wire logic                    trap_handler_present_i,
  output logic                         device_reset_o
);
  import frpe_pkg::*;

  // ---------------------------------------------------------------------------
  // Code helpers
  // ---------------------------------------------------------------------------
  // Check bits of a Hamming code with data at non power-of-two positions
  function automatic logic [5:0] ecc_parity(input logic [47:0] data);
    logic [5:0] par;
    logic [6:0] pos;
    par = 6'h00;
    pos = 7'h03;
    for (int i = 0; i < 48; i++) begin
      if ((pos & (pos - 7'h01)) == 7'h00) begin
        pos = pos + 7'h01;
      end
      if (data[i]) begin
        par = par ^ pos[5:0];
      end
      pos = pos + 7'h01;
    end
    return par;
  endfunction : ecc_parity

  // Flip the data bit that the syndrome points at, if any
  function automatic logic [47:0] ecc_flip(input logic [47:0] data, input logic [5:0] syn);
    logic [47:0] res;
    logic [6:0]  pos;
    res = data;
    pos = 7'h03;
    for (int i = 0; i < 48; i++) begin
      if ((pos & (pos - 7'h01)) == 7'h00) begin
        pos = pos + 7'h01;
      end
      if (pos[5:0] == syn) begin
        res[i] = ~data[i];
      end
      pos = pos + 7'h01;
    end
    return res;
  endfunction : ecc_flip

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  frpe_seq_e       seq_q,        seq_d;
  logic [15:0]     word_q [4];
  logic [15:0]     word_d [4];
  logic [1:0]      widx_q,       widx_d;
  logic [5:0]      pair_q,       pair_d;
  logic [23:0]     src_q,        src_d;
  logic [23:0]     dst_q,        dst_d;
  logic            packed_q,     packed_d;
  logic            ram_rd_q,     ram_rd_d;
  logic            flash_wr_q,   flash_wr_d;
  frpe_codeword_s  wdata_q,      wdata_d;
  logic            done_irq_q,   done_irq_d;
  logic            done_flag_q,  done_flag_d;
  logic            ce_flag_q,    ce_flag_d;
  logic            ce_en_q,      ce_en_d;
  logic            ue_flag_q,    ue_flag_d;
  logic [7:0]      exp_sec_q,    exp_sec_d;
  logic [7:0]      act_sec_q,    act_sec_d;
  logic [7:0]      synd_q,       synd_d;
  logic            exp_dbl_q,    exp_dbl_d;
  logic            act_dbl_q,    act_dbl_d;
  logic            fvalid_q,     fvalid_d;
  logic [47:0]     fdata_q,      fdata_d;
  logic            irq_q,        irq_d;
  logic            trap_q,       trap_d;
  logic            dev_rst_q,    dev_rst_d;
  logic [15:0]     rdata_q,      rdata_d;
  logic            busy_q,       busy_d;

  logic [23:0]     instr_lo;
  logic [23:0]     instr_hi;
  logic            start_req;
  logic [5:0]      rd_par;
  logic [5:0]      rd_syn;
  logic            rd_ovr;
  logic            rd_single;
  logic            rd_double;

  // ---------------------------------------------------------------------------
  // Row sequencer
  // ---------------------------------------------------------------------------
  assign start_req = reg_wr_i && (reg_addr_i == REG_CTRL) && reg_wdata_i[CTRL_START_BIT];

  assign instr_lo = {word_q[1][7:0], word_q[0]};
  assign instr_hi = packed_q ? {word_q[1][15:8], word_q[2]} : {word_q[3][7:0], word_q[2]};

  always_comb begin
    seq_d      = seq_q;
    word_d     = word_q;
    widx_d     = widx_q;
    pair_d     = pair_q;
    src_d      = src_q;
    dst_d      = dst_q;
    packed_d   = packed_q;
    ram_rd_d   = 1'b0;
    flash_wr_d = 1'b0;
    wdata_d    = wdata_q;
    done_irq_d = 1'b0;
    done_flag_d = done_flag_q;
    if (seq_q == SEQ_IDLE && reg_wr_i) begin
      if (reg_addr_i == REG_SRC_LO) begin
        src_d[15:0] = reg_wdata_i;
      end else if (reg_addr_i == REG_SRC_HI) begin
        src_d[23:16] = reg_wdata_i[7:0];
      end else if (reg_addr_i == REG_DST_LO) begin
        dst_d[15:0] = reg_wdata_i;
      end else if (reg_addr_i == REG_DST_HI) begin
        dst_d[23:16] = reg_wdata_i[7:0];
      end else if (reg_addr_i == REG_CTRL) begin
        packed_d    = reg_wdata_i[CTRL_FORMAT_BIT];
        done_flag_d = done_flag_q & ~reg_wdata_i[CTRL_DONE_BIT];
      end
    end
    case (seq_q)
      SEQ_IDLE: begin
        if (start_req) begin
          seq_d       = SEQ_FETCH;
          pair_d      = 6'h00;
          widx_d      = 2'h0;
          done_flag_d = 1'b0;
        end
      end
      SEQ_FETCH: begin
        ram_rd_d = 1'b1;
        seq_d    = SEQ_ISSUE;
      end
      SEQ_ISSUE: begin
        seq_d = SEQ_CAP;
      end
      SEQ_CAP: begin
        word_d[widx_q] = ram_rdata_i;
        src_d          = src_q + RAM_STEP;
        widx_d         = widx_q + 2'h1;
        if (widx_q == (packed_q ? LAST_WORD_PACKED : LAST_WORD_PLAIN)) begin
          seq_d = SEQ_PROG;
        end else begin
          seq_d = SEQ_FETCH;
        end
      end
      SEQ_PROG: begin
        wdata_d.data    = {instr_hi, instr_lo};
        wdata_d.check   = ecc_parity({instr_hi, instr_lo});
        wdata_d.dbl_par = ^{instr_hi, instr_lo, ecc_parity({instr_hi, instr_lo})};
        flash_wr_d      = 1'b1;
        seq_d           = SEQ_WAIT;
      end
      SEQ_WAIT: begin
        if (flash_done_i) begin
          dst_d  = dst_q + FLASH_STEP;
          widx_d = 2'h0;
          pair_d = pair_q + 6'h01;
          if (pair_q == LAST_PAIR) begin
            seq_d = SEQ_DONE;
          end else begin
            seq_d = SEQ_FETCH;
          end
        end
      end
      SEQ_DONE: begin
        done_irq_d  = 1'b1;
        done_flag_d = 1'b1;
        seq_d       = SEQ_IDLE;
      end
      default: begin
        seq_d = SEQ_IDLE;
      end
    endcase
    busy_d = (seq_d != SEQ_IDLE);
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      seq_q       <= SEQ_IDLE;
      for (int i = 0; i < 4; i++) begin
        word_q[i] <= REG16_RST;
      end
      widx_q      <= 2'h0;
      pair_q      <= 6'h00;
      src_q       <= ADDR24_RST;
      dst_q       <= ADDR24_RST;
      packed_q    <= 1'b0;
      ram_rd_q    <= 1'b0;
      flash_wr_q  <= 1'b0;
      wdata_q     <= '0;
      done_irq_q  <= 1'b0;
      done_flag_q <= 1'b0;
      busy_q      <= 1'b0;
    end else begin
      seq_q       <= seq_d;
      word_q      <= word_d;
      widx_q      <= widx_d;
      pair_q      <= pair_d;
      src_q       <= src_d;
      dst_q       <= dst_d;
      packed_q    <= packed_d;
      ram_rd_q    <= ram_rd_d;
      flash_wr_q  <= flash_wr_d;
      wdata_q     <= wdata_d;
      done_irq_q  <= done_irq_d;
      done_flag_q <= done_flag_d;
      busy_q      <= busy_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Read-path check and correction, status and flag registers
  // ---------------------------------------------------------------------------
  always_comb begin
    rd_par    = ecc_parity(fetch_word_i.data);
    rd_syn    = rd_par ^ fetch_word_i.check;
    rd_ovr    = ^{fetch_word_i.data, fetch_word_i.check, fetch_word_i.dbl_par};
    rd_single = fetch_valid_i && rd_ovr;
    rd_double = fetch_valid_i && !rd_ovr && (rd_syn != 6'h00);
  end

  always_comb begin
    fvalid_d  = fetch_valid_i;
    fdata_d   = fdata_q;
    exp_sec_d = exp_sec_q;
    act_sec_d = act_sec_q;
    synd_d    = synd_q;
    exp_dbl_d = exp_dbl_q;
    act_dbl_d = act_dbl_q;
    ce_en_d   = ce_en_q;
    ce_flag_d = ce_flag_q;
    ue_flag_d = ue_flag_q;
    trap_d    = 1'b0;
    dev_rst_d = 1'b0;
    if (reg_wr_i && reg_addr_i == REG_IRQ_EN0) begin
      ce_en_d = reg_wdata_i[EN_CE_BIT];
    end else if (reg_wr_i && reg_addr_i == REG_IRQ_FLAG0) begin
      ce_flag_d = ce_flag_q & ~reg_wdata_i[FLAG_CE_BIT];
    end else if (reg_wr_i && reg_addr_i == REG_IRQ_CTRL4) begin
      ue_flag_d = ue_flag_q & ~reg_wdata_i[CTRL4_UE_BIT];
    end
    if (fetch_valid_i) begin
      if (rd_single) begin
        fdata_d = ecc_flip(fetch_word_i.data, rd_syn);
      end else begin
        fdata_d = fetch_word_i.data;
      end
    end
    if (rd_single || rd_double) begin
      exp_sec_d = {2'b00, rd_par};
      act_sec_d = {2'b00, fetch_word_i.check};
      synd_d    = {2'b00, rd_syn};
      exp_dbl_d = ^{fetch_word_i.data, rd_par};
      act_dbl_d = fetch_word_i.dbl_par;
    end
    if (rd_single) begin
      ce_flag_d = 1'b1;
    end
    if (rd_double) begin
      ue_flag_d = 1'b1;
      trap_d    = 1'b1;
      dev_rst_d = !trap_handler_present_i;
    end
    irq_d = ce_flag_d && ce_en_d;
  end

  // Register read mux; stored check bits appear only in ECC status
  always_comb begin
    rdata_d = REG16_RST;
    if (reg_rd_i) begin
      if (reg_addr_i == REG_CTRL) begin
        rdata_d[CTRL_FORMAT_BIT] = packed_q;
        rdata_d[CTRL_START_BIT]  = (seq_q != SEQ_IDLE);
        rdata_d[CTRL_DONE_BIT]   = done_flag_q;
      end else if (reg_addr_i == REG_SRC_LO) begin
        rdata_d = src_q[15:0];
      end else if (reg_addr_i == REG_SRC_HI) begin
        rdata_d = {FIELD8_RST, src_q[23:16]};
      end else if (reg_addr_i == REG_DST_LO) begin
        rdata_d = dst_q[15:0];
      end else if (reg_addr_i == REG_DST_HI) begin
        rdata_d = {FIELD8_RST, dst_q[23:16]};
      end else if (reg_addr_i == REG_IRQ_FLAG0) begin
        rdata_d[FLAG_CE_BIT] = ce_flag_q;
      end else if (reg_addr_i == REG_IRQ_EN0) begin
        rdata_d[EN_CE_BIT] = ce_en_q;
      end else if (reg_addr_i == REG_IRQ_CTRL4) begin
        rdata_d[CTRL4_UE_BIT] = ue_flag_q;
      end else if (reg_addr_i == REG_ECC_STAT_LO) begin
        rdata_d = {act_sec_q, exp_sec_q};
      end else if (reg_addr_i == REG_ECC_STAT_HI) begin
        rdata_d[7:0]              = synd_q;
        rdata_d[STAT_EXP_DBL_BIT] = exp_dbl_q;
        rdata_d[STAT_ACT_DBL_BIT] = act_dbl_q;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      fvalid_q  <= 1'b0;
      fdata_q   <= '0;
      exp_sec_q <= FIELD8_RST;
      act_sec_q <= FIELD8_RST;
      synd_q    <= FIELD8_RST;
      exp_dbl_q <= 1'b0;
      act_dbl_q <= 1'b0;
      ce_en_q   <= 1'b0;
      ce_flag_q <= 1'b0;
      ue_flag_q <= 1'b0;
      trap_q    <= 1'b0;
      dev_rst_q <= 1'b0;
      irq_q     <= 1'b0;
      rdata_q   <= REG16_RST;
    end else begin
      fvalid_q  <= fvalid_d;
      fdata_q   <= fdata_d;
      exp_sec_q <= exp_sec_d;
      act_sec_q <= act_sec_d;
      synd_q    <= synd_d;
      exp_dbl_q <= exp_dbl_d;
      act_dbl_q <= act_dbl_d;
      ce_en_q   <= ce_en_d;
      ce_flag_q <= ce_flag_d;
      ue_flag_q <= ue_flag_d;
      trap_q    <= trap_d;
      dev_rst_q <= dev_rst_d;
      irq_q     <= irq_d;
      rdata_q   <= rdata_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign reg_rdata_o      = rdata_q;
  assign ram_rd_o         = ram_rd_q;
  assign ram_addr_o       = src_q;
  assign flash_wr_o       = flash_wr_q;
  assign flash_addr_o     = dst_q;
  assign flash_wdata_o    = wdata_q;
  assign fetch_valid_o    = fvalid_q;
  assign fetch_data_o     = fdata_q;
  assign busy_o           = busy_q;
  assign flash_done_irq_o = done_irq_q;
  assign ecc_irq_o        = irq_q;
  assign hard_trap_o      = trap_q;
  assign device_reset_o   = dev_rst_q;

endmodule : frpe_top

// ---- shared/frpe_pkg.sv ----
// Package of constants and types for the flash row programmer and ECC unit
package frpe_pkg;

  // ---------------------------------------------------------------------------
  // Register port
  // ---------------------------------------------------------------------------
  localparam int          ADDR_W            = 8;
  localparam int          DATA_W            = 16;
  localparam logic [7:0]  REG_CTRL          = 8'h00;
  localparam logic [7:0]  REG_SRC_LO        = 8'h02;
  localparam logic [7:0]  REG_SRC_HI        = 8'h04;
  localparam logic [7:0]  REG_DST_LO        = 8'h06;
  localparam logic [7:0]  REG_DST_HI        = 8'h08;
  localparam logic [7:0]  REG_IRQ_FLAG0     = 8'h0A;
  localparam logic [7:0]  REG_IRQ_EN0       = 8'h0C;
  localparam logic [7:0]  REG_IRQ_CTRL4     = 8'h0E;
  localparam logic [7:0]  REG_ECC_STAT_LO   = 8'h10;
  localparam logic [7:0]  REG_ECC_STAT_HI   = 8'h12;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int          CTRL_FORMAT_BIT   = 9;
  localparam int          CTRL_START_BIT    = 15;
  localparam int          CTRL_DONE_BIT     = 14;
  localparam int          FLAG_CE_BIT       = 13;
  localparam int          EN_CE_BIT         = 13;
  localparam int          CTRL4_UE_BIT      = 1;
  localparam int          STAT_EXP_DBL_BIT  = 8;
  localparam int          STAT_ACT_DBL_BIT  = 9;

  // ---------------------------------------------------------------------------
  // Reset values and row geometry
  // ---------------------------------------------------------------------------
  localparam logic [15:0] REG16_RST         = 16'h0000;
  localparam logic [23:0] ADDR24_RST        = 24'h000000;
  localparam logic [7:0]  FIELD8_RST        = 8'h00;
  localparam int          ROW_INSTR         = 128;
  localparam int          ROW_PAIRS         = ROW_INSTR / 2;
  localparam logic [5:0]  LAST_PAIR         = 6'(ROW_PAIRS - 1);
  localparam logic [23:0] RAM_STEP          = 24'h000002;
  localparam logic [23:0] FLASH_STEP        = 24'h000004;
  localparam logic [1:0]  LAST_WORD_PLAIN   = 2'h3;
  localparam logic [1:0]  LAST_WORD_PACKED  = 2'h2;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic        dbl_par;
    logic [5:0]  check;
    logic [47:0] data;
  } frpe_codeword_s;

  typedef enum logic [2:0] {
    SEQ_IDLE  = 3'b000,
    SEQ_FETCH = 3'b001,
    SEQ_ISSUE = 3'b010,
    SEQ_CAP   = 3'b011,
    SEQ_PROG  = 3'b100,
    SEQ_WAIT  = 3'b101,
    SEQ_DONE  = 3'b110
  } frpe_seq_e;

endpackage : frpe_pkg

// ---- tb/frpe_top_properties.sv ----
// Port checks for the flash row programmer and ECC unit
`timescale 1ns/1ps

module frpe_top_checker (
  input wire logic                     core_clk_i,
  input wire logic                     reset_i,
  input wire logic                     ram_rd_o,
  input wire logic [23:0]              ram_addr_o,
  input wire logic                     flash_wr_o,
  input wire logic [23:0]              flash_addr_o,
  input wire frpe_pkg::frpe_codeword_s flash_wdata_o,
  input wire logic                     fetch_valid_i,
  input wire frpe_pkg::frpe_codeword_s fetch_word_i,
  input wire logic                     fetch_valid_o,
  input wire logic [47:0]              fetch_data_o,
  input wire logic                     busy_o,
  input wire logic                     flash_done_irq_o,
  input wire logic                     hard_trap_o,
  input wire logic                     trap_handler_present_i,
  input wire logic                     device_reset_o
);
  import frpe_pkg::*;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);

  sequence s_prog_issue;
    flash_wr_o ##1 !flash_wr_o;
  endsequence
  sequence s_word_held;
    $stable(flash_wdata_o) [*4];
  endsequence

  a_prog_one_pulse: assert property (flash_wr_o |-> s_prog_issue)
    else $error("program strobe longer than one cycle");
  a_prog_word_held: assert property (flash_wr_o |=> s_word_held)
    else $error("program word changed too soon");
  a_dst_step_four: assert property (busy_o && $past(busy_o) && $changed(flash_addr_o)
    |-> flash_addr_o == $past(flash_addr_o) + FLASH_STEP) else $error("destination step wrong");
  a_src_step_two: assert property (busy_o && $past(busy_o) && $changed(ram_addr_o)
    |-> ram_addr_o == $past(ram_addr_o) + RAM_STEP) else $error("source step wrong");
  a_row_end_irq: assert property ($fell(busy_o) |-> flash_done_irq_o)
    else $error("row ended without completion pulse");
  a_fetch_answer: assert property (fetch_valid_i |=> fetch_valid_o)
    else $error("read word not answered");
  a_fetch_quiet: assert property (!fetch_valid_i |=> !fetch_valid_o)
    else $error("spurious read answer");
  a_dbl_data_kept: assert property (fetch_valid_i ##1 hard_trap_o |-> fetch_data_o == $past(fetch_word_i.data))
    else $error("double error data altered");
  a_trap_from_read: assert property (hard_trap_o |-> fetch_valid_o)
    else $error("trap without a read");
  a_reset_unhandled: assert property (hard_trap_o && !trap_handler_present_i
    && !$past(trap_handler_present_i) |-> device_reset_o) else $error("missing device reset");
  a_reset_with_trap: assert property (device_reset_o |-> hard_trap_o)
    else $error("device reset without trap");
endmodule : frpe_top_checker

bind frpe_top frpe_top_checker i_frpe_top_checker (.*);

// ---- tb/frpe_far_model.sv ----
// Behavioural data RAM and flash array facing the row programmer
`timescale 1ns/1ps

module frpe_far_model (
  input  wire logic                     core_clk_i,
  input  wire logic                     reset_i,
  input  wire logic                     ram_rd_i,
  input  wire logic [23:0]              ram_addr_i,
  output logic      [15:0]              ram_rdata_o = 16'h0000,
  input  wire logic                     flash_wr_i,
  input  wire logic [23:0]              flash_addr_i,
  input  wire frpe_pkg::frpe_codeword_s flash_wdata_i,
  output logic                          flash_done_o = 1'b0,
  input  wire logic                     slow_i,
  input  wire logic                     rd_req_i,
  input  wire logic [5:0]               rd_idx_i,
  input  wire logic [54:0]              flip_i,
  output logic                          fetch_valid_o = 1'b0,
  output frpe_pkg::frpe_codeword_s      fetch_word_o = '0,
  output logic      [15:0]              writes_o
);
  import frpe_pkg::*;
  frpe_codeword_s mem [64];
  logic [3:0]     wait_q;

  // Data toggles outside its one valid cycle so a late capture shows up
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      ram_rdata_o <= 16'h0000;
      writes_o <= 16'h0000;
      wait_q <= 4'h0;
      flash_done_o <= 1'b0;
      fetch_valid_o <= 1'b0;
      fetch_word_o <= '0;
    end else begin
      ram_rdata_o <= ram_rd_i ? {~ram_addr_i[8:1], ram_addr_i[8:1]} : ~ram_rdata_o;
      if (flash_wr_i) begin
        mem[flash_addr_i[7:2]] <= flash_wdata_i;
        writes_o <= writes_o + 16'h0001;
        wait_q <= slow_i ? 4'h6 : 4'h1;
      end else if (wait_q != 4'h0) begin
        wait_q <= wait_q - 4'h1;
      end
      flash_done_o <= (wait_q == 4'h1);
      fetch_valid_o <= rd_req_i;
      fetch_word_o <= rd_req_i ? frpe_codeword_s'(mem[rd_idx_i] ^ flip_i) : frpe_codeword_s'(~fetch_word_o);
    end
  end
endmodule : frpe_far_model

// ---- tb/tb.sv ----
// Self-checking bench for the flash row programmer and ECC unit
`timescale 1ns/1ps

`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin miscompares++; \
  $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); end end

module tb;
  import frpe_pkg::*;
  localparam logic [23:0] SRC_A = 24'h001000;
  localparam logic [23:0] SRC_B = 24'h002000;
  localparam logic [54:0] MASKS [7] = '{55'h0, 55'h20, 55'h4000000000000, 55'h40000000000000,
                                        55'h220, 55'h800000000001, 55'h0};
  localparam logic [6:0]  HND = 7'h5F;
  logic                 core_clk_i = 1'b0;
  logic                 reset_i = 1'b1;
  logic [7:0]           reg_addr_i = 8'h00;
  logic [15:0]          reg_wdata_i = 16'h0000;
  logic                 reg_wr_i = 1'b0;
  logic                 reg_rd_i = 1'b0;
  logic                 trap_handler_present_i = 1'b1;
  logic                 slow = 1'b0;
  logic                 rd_req = 1'b0;
  logic [5:0]           rd_idx = 6'h00;
  logic [54:0]          flip = 55'h0;
  logic [15:0]          reg_rdata_o, ram_rdata_i, writes;
  logic [23:0]          ram_addr_o, flash_addr_o;
  logic [47:0]          fetch_data_o;
  logic                 ram_rd_o, flash_wr_o, flash_done_i, fetch_valid_i, fetch_valid_o, busy_o;
  logic                 flash_done_irq_o, ecc_irq_o, hard_trap_o, device_reset_o;
  frpe_codeword_s       flash_wdata_o, fetch_word_i;
  logic [15:0]          exp_lo = 16'h0000;
  logic [15:0]          exp_hi = 16'h0000;
  int                   miscompares = 0;
  int                   checks_done = 0;

  frpe_top i_frpe_top (.*);
  frpe_far_model i_frpe_far_model (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .ram_rd_i(ram_rd_o), .ram_addr_i(ram_addr_o),
    .ram_rdata_o(ram_rdata_i), .flash_wr_i(flash_wr_o), .flash_addr_i(flash_addr_o),
    .flash_wdata_i(flash_wdata_o), .flash_done_o(flash_done_i), .slow_i(slow), .rd_req_i(rd_req),
    .rd_idx_i(rd_idx), .flip_i(flip), .fetch_valid_o(fetch_valid_i), .fetch_word_o(fetch_word_i),
    .writes_o(writes));

  initial begin
    forever #2.5 core_clk_i = ~core_clk_i;
  end

  // ---------------------------------------------------------------------------
  // Reference code and register access
  // ---------------------------------------------------------------------------
  function automatic logic [5:0] ham(input logic [47:0] d);
    logic [5:0] c;
    int j;
    c = 6'h00;
    j = 0;
    for (int p = 3; p < 55; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (d[j]) c ^= 6'(p);
        j++;
      end
    end
    return c;
  endfunction : ham

  function automatic frpe_codeword_s exp_cw(input logic fmt, input logic [23:0] src, input int k);
    logic [15:0] w [4];
    frpe_codeword_s cw;
    for (int n = 0; n < 4; n++) begin
      w[n] = ramw(src + 24'(2 * ((fmt ? 3 : 4) * k + n)));
    end
    cw.data = fmt ? {w[1][15:8], w[2], w[1][7:0], w[0]} : {w[3][7:0], w[2], w[1][7:0], w[0]};
    cw.check = ham(cw.data);
    cw.dbl_par = ^{cw.data, cw.check};
    return cw;
  endfunction : exp_cw

  function automatic logic [15:0] ramw(input logic [23:0] a);
    return {~a[8:1], a[8:1]};
  endfunction : ramw

  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask : reg_wr

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge core_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    `CHK(reg_rdata_o & m, e)
  endtask : rd_chk

  // ---------------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------------
  task automatic run_row(input logic fmt, input logic [23:0] src);
    logic [15:0] w0;
    int n;
    w0 = writes;
    reg_wr(REG_SRC_LO, src[15:0]);
    reg_wr(REG_SRC_HI, {8'h00, src[23:16]});
    reg_wr(REG_DST_LO, 16'h0000);
    reg_wr(REG_DST_HI, 16'h0000);
    reg_wr(REG_CTRL, {1'b1, 5'h00, fmt, 9'h000});
    n = 0;
    while (flash_done_irq_o !== 1'b1 && n < 4000) begin
      @(negedge core_clk_i);
      n++;
    end
    `CHK(busy_o, 1'b0)
    @(negedge core_clk_i);
    `CHK(flash_done_irq_o, 1'b0)
    `CHK(writes - w0, 16'(ROW_PAIRS))
    for (int k = 0; k < ROW_PAIRS; k++) `CHK(i_frpe_far_model.mem[k], exp_cw(fmt, src, k))
    rd_chk(REG_SRC_LO, 16'hFFFF, src[15:0] + 16'(ROW_PAIRS * (fmt ? 6 : 8)));
    rd_chk(REG_DST_LO, 16'hFFFF, 16'h0100);
    rd_chk(REG_CTRL, 16'hFFFF, {2'b01, 4'h0, fmt, 9'h000});
    reg_wr(REG_CTRL, {2'b01, 4'h0, fmt, 9'h000});
    $display("test row format %0d done", fmt);
  endtask : run_row

  task automatic fetch_chk(input int k, input logic [54:0] m, input logic hnd);
    frpe_codeword_s cw;
    frpe_codeword_s bad;
    int cnt;
    cw = exp_cw(1'b1, SRC_B, k);
    bad = frpe_codeword_s'(cw ^ m);
    cnt = $countones(m);
    @(posedge core_clk_i);
    trap_handler_present_i <= hnd;
    @(posedge core_clk_i);
    rd_req <= 1'b1;
    rd_idx <= 6'(k);
    flip <= m;
    @(posedge core_clk_i);
    rd_req <= 1'b0;
    @(posedge core_clk_i);
    #1;
    `CHK(fetch_valid_o, 1'b1)
    `CHK(fetch_data_o, cnt < 2 ? cw.data : bad.data)
    `CHK({hard_trap_o, device_reset_o}, {cnt == 2, cnt == 2 && !hnd})
    if (cnt != 0) begin
      exp_lo = {2'b00, bad.check, 2'b00, ham(bad.data)};
      exp_hi = {6'h00, bad.dbl_par, ^{bad.data, ham(bad.data)}, 2'b00, ham(bad.data) ^ bad.check};
    end
    rd_chk(REG_ECC_STAT_LO, 16'hFFFF, exp_lo);
    rd_chk(REG_ECC_STAT_HI, 16'hFFFF, exp_hi);
    rd_chk(REG_IRQ_FLAG0, 16'h2000, {2'b00, cnt == 1, 13'h0000});
    `CHK(ecc_irq_o, 1'b0)
    if (cnt == 1) begin
      reg_wr(REG_IRQ_EN0, 16'h2000);
      rd_chk(REG_IRQ_EN0, 16'h2000, 16'h2000);
      `CHK(ecc_irq_o, 1'b1)
      reg_wr(REG_IRQ_FLAG0, 16'h2000);
      reg_wr(REG_IRQ_EN0, 16'h0000);
      rd_chk(REG_IRQ_FLAG0, 16'h2000, 16'h0000);
      `CHK(ecc_irq_o, 1'b0)
    end
    rd_chk(REG_IRQ_CTRL4, 16'h0002, {14'h0000, cnt == 2, 1'b0});
    reg_wr(REG_IRQ_CTRL4, 16'h0002);
    $display("test read %0d done", k);
  endtask : fetch_chk

  task automatic report_and_stop();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (8) @(posedge core_clk_i);
    reset_i <= 1'b0;
    reg_wr(REG_ECC_STAT_LO, 16'hFFFF);
    rd_chk(REG_ECC_STAT_LO, 16'hFFFF, 16'h0000);
    rd_chk(REG_ECC_STAT_HI, 16'hFFFF, 16'h0000);
    rd_chk(8'hFE, 16'hFFFF, 16'h0000);
    rd_chk(REG_CTRL, 16'hFFFF, 16'h0000);
    $display("test registers done");
    slow <= 1'b1;
    run_row(1'b0, SRC_A);
    slow <= 1'b0;
    run_row(1'b1, SRC_B);
    for (int i = 0; i < 7; i++) fetch_chk(i, MASKS[i], HND[i]);
    report_and_stop();
  end

  initial begin
    repeat (12000) @(posedge core_clk_i);
    miscompares++;
    report_and_stop();
  end
endmodule : tb
